// ---- verilog/fault_timer_pkg.sv ----
// Constants, types and field layout of the windowed fault timer.
// Assumes an APB slave with 32-bit data and a 40 MHz pclk.
package fault_timer_pkg;

    localparam logic [11:0] CTRL_OFFSET      = 12'h000;
    localparam logic [11:0] MODE_OFFSET      = 12'h004;
    localparam logic [11:0] STATUS_OFFSET    = 12'h008;
    localparam logic [7:0]  CTRL_RESET       = 8'h7F;
    localparam int          ACT_BIT          = 7;
    localparam int          TOP_BIT          = 6;
    localparam int          PRESCALE_CYCLES  = 12288;
    localparam int          WAKE_CYCLES      = 4096;
    localparam int          CLK_MHZ          = 40;
    localparam int          RESET_PULSE_NS   = 500;
    // Longest time rounds down, at least one cycle
    localparam int          RESET_PULSE_CYC  = (RESET_PULSE_NS * CLK_MHZ / 1000) < 1 ? 1
                                               : (RESET_PULSE_NS * CLK_MHZ / 1000);

    typedef enum logic [1:0] {
        RUN,
        HALT_TAIL,
        HALT_STOP,
        WAKE_DELAY
    } power_state_e;

    typedef struct packed {
        logic always_on;
        logic halt_reset_option;
        logic osc_interrupt_enable;
    } mode_cfg_s;

endpackage

// ---- verilog/fault_prescaler.sv ----
// Prescaler, counting only while run is high, producing a one-cycle tick.
// Assumes a single clock; never cleared by register writes.
`timescale 1ns/1ps
`default_nettype none
module fault_prescaler
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      tick
);

    logic [13:0] count_r;

    // Count when allowed, wrap at end of period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_r <= 14'h0000;
        else if (run)
        begin
            if (count_r == 14'(fault_timer_pkg::PRESCALE_CYCLES - 1))
                count_r <= 14'h0000;
            else
                count_r <= count_r + 14'h0001;
        end
    end

    assign tick = run && (count_r == 14'(fault_timer_pkg::PRESCALE_CYCLES - 1));

endmodule
`default_nettype wire

// ---- verilog/windowed_fault_timer.sv ----
// Windowed fault timer: 7-bit down-counter with reset generation.
// Assumes APB master on pclk; halt and wake events synchronous to pclk.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module windowed_fault_timer
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_instr,
    input  wire logic        ext_interrupt,
    input  wire logic        osc_interrupt,
    output logic             halt_blocked,
    output logic             mcu_reset_n
);

    ////////////////////////////////////////////////////////////////
    // Registers and decode

    logic [7:0]                      ctrl_r;
    fault_timer_pkg::mode_cfg_s      mode_r;
    fault_timer_pkg::power_state_e   pstate_r;
    logic [12:0]                     wake_cnt_r;
    logic [4:0]                      pulse_cnt_r;
    logic                            active;
    logic                            wr_en;
    logic                            wr_ctrl;
    logic                            tick;
    logic                            count_run;
    logic                            expire;
    logic                            halt_reset;

    assign wr_en   = psel && penable && pwrite;
    assign wr_ctrl = wr_en && (paddr == fault_timer_pkg::CTRL_OFFSET) && pstrb[0];
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Always-on option overrides activation bit
    assign active = mode_r.always_on || ctrl_r[fault_timer_pkg::ACT_BIT];

    ////////////////////////////////////////////////////////////////
    // Prescaler

    // Counting stops only in halt stop and wake delay; wait mode is ignored
    assign count_run = (pstate_r == fault_timer_pkg::RUN) ||
                       (pstate_r == fault_timer_pkg::HALT_TAIL);

    fault_prescaler u_prescaler
    (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (count_run),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////
    // Control register

    // Write loads bits 6:0 and can only set bit 7; activation sticks once set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_r <= fault_timer_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_r <= {ctrl_r[7] | pwdata[7], pwdata[6:0]};
        else if (tick)
            ctrl_r <= {ctrl_r[7], ctrl_r[6:0] - 7'h01};
    end

    // Mode options written by software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_r <= '0;
        else if (wr_en && (paddr == fault_timer_pkg::MODE_OFFSET) && pstrb[0])
            mode_r <= fault_timer_pkg::mode_cfg_s'(pwdata[2:0]);
    end

    // Read mux: count visible, unmapped reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                fault_timer_pkg::CTRL_OFFSET:   prdata <= {24'h000000, ctrl_r};
                fault_timer_pkg::MODE_OFFSET:   prdata <= {29'h0, mode_r};
                fault_timer_pkg::STATUS_OFFSET: prdata <= {30'h0, pstate_r};
                default:                        prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power state

    // Halt with reset option fires instead of halting while active, unless oscillator interrupt is enabled
    assign halt_reset = halt_instr && (pstate_r == fault_timer_pkg::RUN) && active &&
                        !mode_r.osc_interrupt_enable && mode_r.halt_reset_option;
    assign halt_blocked = halt_reset;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pstate_r <= fault_timer_pkg::RUN;
        else
        begin
            unique case (pstate_r)
                fault_timer_pkg::RUN:
                    if (halt_instr && !halt_reset)
                        pstate_r <= mode_r.osc_interrupt_enable ? fault_timer_pkg::HALT_STOP
                                                                : fault_timer_pkg::HALT_TAIL;
                fault_timer_pkg::HALT_TAIL:
                    if (ext_interrupt)
                        pstate_r <= fault_timer_pkg::WAKE_DELAY;
                    else if (tick)
                        pstate_r <= fault_timer_pkg::HALT_STOP;
                fault_timer_pkg::HALT_STOP:
                    if (ext_interrupt || (mode_r.osc_interrupt_enable && osc_interrupt))
                        pstate_r <= fault_timer_pkg::WAKE_DELAY;
                fault_timer_pkg::WAKE_DELAY:
                    if (wake_cnt_r == 13'(fault_timer_pkg::WAKE_CYCLES - 1))
                        pstate_r <= fault_timer_pkg::RUN;
            endcase
        end
    end

    // Wake delay counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_cnt_r <= 13'h0000;
        else if (pstate_r == fault_timer_pkg::WAKE_DELAY)
            wake_cnt_r <= wake_cnt_r + 13'h0001;
        else
            wake_cnt_r <= 13'h0000;
    end

    ////////////////////////////////////////////////////////////////
    // Reset generation

    // Expiry on top bit clear while active outside halt stop and wake delay, or halt reset
    assign expire = (active && !ctrl_r[fault_timer_pkg::TOP_BIT] &&
                     (pstate_r != fault_timer_pkg::HALT_STOP) &&
                     (pstate_r != fault_timer_pkg::WAKE_DELAY)) || halt_reset;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_cnt_r <= 5'h00;
        else if (pulse_cnt_r != 5'h00)
            pulse_cnt_r <= pulse_cnt_r - 5'h01;
        else if (expire)
            pulse_cnt_r <= 5'(fault_timer_pkg::RESET_PULSE_CYC);
    end

    assign mcu_reset_n = (pulse_cnt_r == 5'h00);

    ////////////////////////////////////////////////////////////////
    // Assertions

    a_expire_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        (pulse_cnt_r == 5'h00 && expire) |=> !mcu_reset_n [*8])
        else $error("reset pulse not started on expiry");

    a_act_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[7] |=> ctrl_r[7])
        else $error("activation bit cleared without reset");

    a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && pwdata[7:6] == 2'b10 && pstate_r == fault_timer_pkg::RUN && pulse_cnt_r == 5'h00)
        |=> ##1 !mcu_reset_n)
        else $error("software reset not generated");

    a_write_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> ctrl_r[6:0] == $past(pwdata[6:0]))
        else $error("control write not loaded");

    a_tick_dec: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !wr_ctrl) |=> ctrl_r[6:0] == $past(ctrl_r[6:0]) - 7'h01)
        else $error("count not decremented on tick");

    a_halt_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::HALT_STOP && !wr_ctrl) |=> $stable(ctrl_r[6:0]))
        else $error("counter moved while halted");

    a_inactive_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!active && !halt_reset && pulse_cnt_r == 5'h00) |=> mcu_reset_n)
        else $error("reset while inactive");

    a_wake_delay: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::HALT_STOP && ext_interrupt) |=>
        pstate_r == fault_timer_pkg::WAKE_DELAY [*8])
        else $error("wake delay too short");

    a_halt_reset: assert property (@(posedge pclk) disable iff (!presetn)
        (halt_reset && pulse_cnt_r == 5'h00) |=> !mcu_reset_n)
        else $error("halt reset missing");

    ////////////////////////////////////////////////////////////////
    // Assertion helpers

    logic [14:0] tick_gap_r;  // Cycles since last prescaler tick
    logic [5:0]  low_run_r;   // Length of current reset pulse

    // Cycles counted since the last prescaler tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_gap_r <= 15'h0000;
        else if (tick)
            tick_gap_r <= 15'h0000;
        else if (count_run)
            tick_gap_r <= tick_gap_r + 15'h0001;
    end

    // Cycles the reset request has been low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_run_r <= 6'h00;
        else if (!mcu_reset_n)
            low_run_r <= low_run_r + 6'h01;
        else
            low_run_r <= 6'h00;
    end

    ////////////////////////////////////////////////////////////////
    // Prescaler and reset pulse checks

    // Tick only after a full prescaler period
    a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        tick |-> tick_gap_r == 15'(fault_timer_pkg::PRESCALE_CYCLES - 1))
        else $error("prescaler period wrong");

    // Gap never runs past one period
    a_prescale_bound: assert property (@(posedge pclk) disable iff (!presetn)
        tick_gap_r < 15'(fault_timer_pkg::PRESCALE_CYCLES))
        else $error("prescaler tick missed");

    // No tick while counting is frozen
    a_tick_halted: assert property (@(posedge pclk) disable iff (!presetn)
        !count_run |-> !tick)
        else $error("tick while frozen");

    // Reset pulse never longer than its width
    a_pulse_length: assert property (@(posedge pclk) disable iff (!presetn)
        !mcu_reset_n |-> low_run_r < 6'(fault_timer_pkg::RESET_PULSE_CYC))
        else $error("reset pulse too long");

    // Reset pulse ends only after its full width
    a_pulse_full: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mcu_reset_n) |-> low_run_r == 6'(fault_timer_pkg::RESET_PULSE_CYC))
        else $error("reset pulse too short");

    // Top bit set keeps the reset quiet
    a_no_early_fire: assert property (@(posedge pclk) disable iff (!presetn)
        (active && ctrl_r[fault_timer_pkg::TOP_BIT] && !halt_reset && pulse_cnt_r == 5'h00) |=> mcu_reset_n)
        else $error("reset with top bit set");

    // Always-on option fires without activation bit
    a_always_on: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_r.always_on && !ctrl_r[fault_timer_pkg::TOP_BIT] && pstate_r == fault_timer_pkg::RUN &&
         pulse_cnt_r == 5'h00) |=> !mcu_reset_n)
        else $error("always-on expiry missing");

    ////////////////////////////////////////////////////////////////
    // Power state checks

    // Plain halt keeps counting for one more tick
    a_halt_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::RUN && halt_instr && !halt_reset && !mode_r.osc_interrupt_enable)
        |=> pstate_r == fault_timer_pkg::HALT_TAIL)
        else $error("halt not entered");

    // Active halt freezes at once
    a_active_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::RUN && halt_instr && mode_r.osc_interrupt_enable)
        |=> pstate_r == fault_timer_pkg::HALT_STOP)
        else $error("active halt not entered");

    // Last tick of the halt tail stops the counter
    a_tail_stop: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::HALT_TAIL && tick && !ext_interrupt)
        |=> pstate_r == fault_timer_pkg::HALT_STOP)
        else $error("halt tail did not stop");

    // Oscillator wake only in active halt
    a_osc_wake: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::HALT_STOP && mode_r.osc_interrupt_enable && osc_interrupt)
        |=> pstate_r == fault_timer_pkg::WAKE_DELAY)
        else $error("oscillator wake missed");

    // Plain halt ignores the oscillator
    a_osc_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::HALT_STOP && !mode_r.osc_interrupt_enable && !ext_interrupt)
        |=> pstate_r == fault_timer_pkg::HALT_STOP)
        else $error("halt left without wake");

    // Wake delay held until its count ends
    a_wake_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::WAKE_DELAY && wake_cnt_r != 13'(fault_timer_pkg::WAKE_CYCLES - 1))
        |=> pstate_r == fault_timer_pkg::WAKE_DELAY)
        else $error("wake delay cut short");

    // Counting resumes only after the full delay
    a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
        (pstate_r == fault_timer_pkg::RUN && $past(pstate_r) == fault_timer_pkg::WAKE_DELAY)
        |-> $past(wake_cnt_r) == 13'(fault_timer_pkg::WAKE_CYCLES - 1))
        else $error("wake delay length wrong");

    // No reset while frozen or waking
    a_halt_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (((pstate_r == fault_timer_pkg::HALT_STOP) || (pstate_r == fault_timer_pkg::WAKE_DELAY)) &&
         pulse_cnt_r == 5'h00) |=> mcu_reset_n)
        else $error("reset while halted");

    ////////////////////////////////////////////////////////////////
    // Register bus checks

    // Count moves only on a write or a tick
    a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_ctrl && !tick) |=> $stable(ctrl_r))
        else $error("control changed unprompted");

    // Mode write lands in one cycle
    a_mode_load: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == fault_timer_pkg::MODE_OFFSET && pstrb[0]) |=> mode_r == $past(pwdata[2:0]))
        else $error("mode write not loaded");

    // Control read returns the current count
    a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == fault_timer_pkg::CTRL_OFFSET)
        |=> prdata == {24'h000000, $past(ctrl_r)})
        else $error("control read wrong");

    c_active_halt: cover property (@(posedge pclk) disable iff (!presetn)
        pstate_r == fault_timer_pkg::HALT_STOP && mode_r.osc_interrupt_enable && osc_interrupt);
    c_always_on: cover property (@(posedge pclk) disable iff (!presetn)
        mode_r.always_on && !ctrl_r[fault_timer_pkg::ACT_BIT] && !mcu_reset_n);
    c_expiry: cover property (@(posedge pclk) disable iff (!presetn)
        active && tick && ctrl_r[6:0] == 7'h40);
    c_halt_wake: cover property (@(posedge pclk) disable iff (!presetn)
        pstate_r == fault_timer_pkg::WAKE_DELAY ##1 pstate_r == fault_timer_pkg::RUN);
    c_soft_reset: cover property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl && pwdata[7:6] == 2'b10);

endmodule
`default_nettype wire

// ---- verif/windowed_fault_timer_tb.sv ----
// Self-checking testbench for the windowed fault timer.
// Assumes the design package is compiled first; bench acts as APB master.
`timescale 1ns/1ps
`default_nettype none
module windowed_fault_timer_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        halt_instr;
    logic        ext_interrupt;
    logic        osc_interrupt;
    logic        halt_blocked;
    logic        mcu_reset_n;
    logic [31:0] q;
    int          num_errors;
    int          samples_checked;
    int          cyc;
    int          t;
    int          t0;

    windowed_fault_timer i_dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .halt_instr(halt_instr), .ext_interrupt(ext_interrupt),
        .osc_interrupt(osc_interrupt), .halt_blocked(halt_blocked), .mcu_reset_n(mcu_reset_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock and cycle count
    initial
    begin
        pclk = 1'b0;
        cyc = 0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    // Compare, bus, reset and halt helpers
    task check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read until the low byte matches
    task poll(input logic [11:0] a, input logic [7:0] v);
        do apb(1'b0, a, 32'h0); while (q[7:0] !== v);
    endtask

    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task halt_pulse;
        @(posedge pclk);
        halt_instr <= 1'b1;
        @(posedge pclk);
        halt_instr <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset_vals;
        apb(1'b0, fault_timer_pkg::CTRL_OFFSET, 32'h0);
        check(q, 32'h7F, "control after reset");
        apb(1'b0, fault_timer_pkg::MODE_OFFSET, 32'h0);
        check(q, 32'h0, "mode after reset");
        apb(1'b0, 12'h00C, 32'h0);
        check(q, 32'h0, "unmapped read");
        check({31'h0, pready}, 32'h1, "bus ready");
        check({31'h0, pslverr}, 32'h0, "bus error");
    endtask

    task t_count;
        int t1;
        repeat (6000) @(posedge pclk);
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'h7F);
        poll(fault_timer_pkg::CTRL_OFFSET, 8'h7E);
        t1 = cyc;
        check(t1 - t0 >= 12288 && t1 - t0 <= 12294, 1, "first tick after write");
        poll(fault_timer_pkg::CTRL_OFFSET, 8'h7D);
        check(cyc - t1 >= 12285 && cyc - t1 <= 12291, 1, "tick period");
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'hC0);
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'h40);
        apb(1'b0, fault_timer_pkg::CTRL_OFFSET, 32'h0);
        check(q, 32'hC0, "activation kept");
        t1 = cyc;
        @(negedge mcu_reset_n);
        check(cyc - t1 <= 12300, 1, "expiry within one tick");
        t1 = cyc;
        @(posedge mcu_reset_n);
        check(cyc - t1, fault_timer_pkg::RESET_PULSE_CYC, "reset pulse width");
        do_reset;
        apb(1'b0, fault_timer_pkg::CTRL_OFFSET, 32'h0);
        check(q, 32'h7F, "inactive after reset");
    endtask

    task t_soft;
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'h3F);
        repeat (5) @(posedge pclk);
        check(mcu_reset_n, 1'b1, "no reset while inactive");
        apb(1'b1, fault_timer_pkg::MODE_OFFSET, 32'h4);
        repeat (3) @(posedge pclk);
        #1 check(mcu_reset_n, 1'b0, "always-on expiry");
        do_reset;
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'h80);
        repeat (3) @(posedge pclk);
        #1 check(mcu_reset_n, 1'b0, "software reset");
        do_reset;
    endtask

    task t_halt;
        apb(1'b1, fault_timer_pkg::MODE_OFFSET, 32'h2);
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'hFF);
        @(posedge pclk);
        halt_instr <= 1'b1;
        #1 check(halt_blocked, 1'b1, "halt blocked");
        @(posedge pclk);
        halt_instr <= 1'b0;
        #1 check(mcu_reset_n, 1'b0, "halt reset");
        do_reset;
        apb(1'b1, fault_timer_pkg::CTRL_OFFSET, 32'hFF);
        halt_pulse;
        apb(1'b0, fault_timer_pkg::STATUS_OFFSET, 32'h0);
        check(q, 32'h1, "halt tail");
        poll(fault_timer_pkg::STATUS_OFFSET, 8'h02);
        apb(1'b0, fault_timer_pkg::CTRL_OFFSET, 32'h0);
        check(q, 32'hFE, "one decrement in halt");
        @(posedge pclk);
        ext_interrupt <= 1'b1;
        @(posedge pclk);
        ext_interrupt <= 1'b0;
        t = cyc;
        poll(fault_timer_pkg::STATUS_OFFSET, 8'h00);
        check(cyc - t >= 4090 && cyc - t <= 4105, 1, "external wake delay");
        apb(1'b1, fault_timer_pkg::MODE_OFFSET, 32'h1);
        halt_pulse;
        apb(1'b0, fault_timer_pkg::STATUS_OFFSET, 32'h0);
        check(q, 32'h2, "active halt freeze");
        @(posedge pclk);
        osc_interrupt <= 1'b1;
        @(posedge pclk);
        osc_interrupt <= 1'b0;
        t = cyc;
        poll(fault_timer_pkg::STATUS_OFFSET, 8'h00);
        check(cyc - t >= 4090 && cyc - t <= 4105, 1, "oscillator wake delay");
        halt_pulse;
        do_reset;
        apb(1'b0, fault_timer_pkg::CTRL_OFFSET, 32'h0);
        check(q, 32'h7F, "reset ends halt");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict, watchdog and main sequence
    task tally_and_finish;
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        tally_and_finish;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, halt_instr, ext_interrupt, osc_interrupt} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        num_errors = 0;
        samples_checked = 0;
        do_reset;
        t0 = cyc;
        t_reset_vals;
        t_count;
        t_soft;
        t_halt;
        tally_and_finish;
    end
endmodule
`default_nettype wire
